// file: rtl/fcd_decoder.sv
// Command decoder of a parallel NOR flash: bus write cycles in, operations out.
`timescale 1ns/1ns
`default_nettype none
module fcd_decoder
    import fcd_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic chipEnable_n,
    input wire logic writeEnable_n,
    input wire logic [ADDR_W-1:0] addrIn,
    input wire logic [DATA_W-1:0] dataIn,
    input wire logic opDone,
    input wire logic opError,
    input wire logic opValidReady,
    output logic opValid,
    output logic [3:0] opKind,
    output logic [ADDR_W-1:0] opAddr,
    output logic [DATA_W-1:0] opData,
    output logic [1:0] readMode,
    output logic [7:0] statusReg,
    output logic busy,
    output logic suspended,
    output logic abortPulse,
    output logic cmdStall
);

    // ****************
    // State
    // ****************
    localparam int OP_W = 4 + ADDR_W + DATA_W;

    typedef struct packed {
        logic [2:0] ceSync;
        logic [2:0] weSync;
        logic [2:0][ADDR_W-1:0] addrSync;
        logic [2:0][DATA_W-1:0] dataSync;
        logic strobeSeen;
        fcd_state_t state;
        fcd_read_mode_t mode;
        logic [ADDR_W-1:0] firstAddr;
        logic [5:0] wordsLeft;
        logic [7:0] status;
        logic busy;
        logic suspended;
        logic abort;
        logic stall;
    } fcd_dec_state_t;

    fcd_dec_state_t s_q;
    fcd_dec_state_t s_d;

    logic fifoInValid;
    logic fifoInReady;
    logic [OP_W-1:0] fifoInData;
    logic [OP_W-1:0] fifoOutData;
    logic fifoOutValid;
    logic opValid_q;
    logic [OP_W-1:0] opWord_q;

    function automatic logic [OP_W-1:0] pack_op(fcd_op_t kind, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        pack_op = {kind, a, d};
    endfunction : pack_op

    // ****************
    // Write cycle capture and command decode
    // ****************
    logic ceAgree;
    logic weAgree;
    logic selectedWrite;
    logic writeEnd;
    logic [ADDR_W-1:0] wAddr;
    logic [DATA_W-1:0] wData;
    logic [CMD_W-1:0] code;

    always_comb begin
        s_d = s_q;
        fifoInValid = 1'b0;
        fifoInData = '0;
        s_d.ceSync = {s_q.ceSync[1:0], chipEnable_n};
        s_d.weSync = {s_q.weSync[1:0], writeEnable_n};
        s_d.addrSync = {s_q.addrSync[1:0], addrIn};
        s_d.dataSync = {s_q.dataSync[1:0], dataIn};
        ceAgree = (s_q.ceSync[1] == s_q.ceSync[2]);
        weAgree = (s_q.weSync[1] == s_q.weSync[2]);
        selectedWrite = ceAgree && weAgree && !s_q.ceSync[2] && !s_q.weSync[2];
        // Whichever strobe rises first ends the write.
        writeEnd = s_q.strobeSeen && ((s_q.ceSync[1] && s_q.ceSync[2]) || (s_q.weSync[1] && s_q.weSync[2]));
        wAddr = s_q.addrSync[2];
        wData = s_q.dataSync[2];
        code = wData[CMD_W-1:0];
        if (selectedWrite) begin
            s_d.strobeSeen = 1'b1;
        end else if (writeEnd) begin
            s_d.strobeSeen = 1'b0;
        end
        s_d.abort = 1'b0;
        s_d.stall = !fifoInReady;

        if (opDone && s_q.busy) begin
            s_d.busy = 1'b0;
            s_d.status = s_q.status | STATUS_READY_BIT;
        end
        // A fresh error sets its bit even when a clear arrives in the same cycle.
        if (opError) begin
            s_d.status = s_d.status | STATUS_ERR_MASK;
        end

        // Only a completed write cycle can launch or advance a command.
        if (writeEnd && fifoInReady) begin
            s_d.state = ST_IDLE;
            unique case (s_q.state)
                ST_IDLE: begin
                    s_d.firstAddr = wAddr;
                    if (code == CMD_READ_ARRAY) begin
                        s_d.mode = RD_ARRAY;
                    end else if (code == CMD_READ_ID) begin
                        s_d.mode = RD_ID;
                    end else if (code == CMD_READ_QUERY) begin
                        s_d.mode = RD_QUERY;
                    end else if (code == CMD_READ_STATUS) begin
                        s_d.mode = RD_STATUS;
                    end else if (code == CMD_CLEAR_STATUS) begin
                        s_d.status = (s_d.status & ~STATUS_ERR_MASK) | (opError ? STATUS_ERR_MASK : 8'h00);
                    end else if (code == CMD_SUSPEND) begin
                        if (s_q.busy && !s_q.suspended) begin
                            s_d.suspended = 1'b1;
                            s_d.abort = 1'b1;
                            s_d.status = s_d.status | STATUS_SUSPEND_MASK | STATUS_READY_BIT;
                            fifoInValid = 1'b1;
                            fifoInData = pack_op(OP_SUSPEND, wAddr, wData);
                        end
                        s_d.mode = RD_STATUS;
                    end else if (code == CMD_CONFIRM) begin
                        if (s_q.suspended) begin
                            s_d.suspended = 1'b0;
                            s_d.status = (s_d.status & ~STATUS_SUSPEND_MASK) & ~STATUS_READY_BIT;
                            fifoInValid = 1'b1;
                            fifoInData = pack_op(OP_RESUME, wAddr, wData);
                        end
                        s_d.mode = RD_STATUS;
                    end else if (!s_q.busy) begin
                        // While an operation other than factory programming runs, only the read, clear status, suspend and confirm commands are honoured.
                        if (code == CMD_WORD_PROG || code == CMD_WORD_PROG_ALT) begin
                            s_d.state = ST_WORD_DATA;
                        end else if (code == CMD_BUF_PROG) begin
                            s_d.state = ST_BUF_COUNT;
                        end else if (code == CMD_FACTORY_PROG) begin
                            s_d.state = ST_FACTORY_CONFIRM;
                        end else if (code == CMD_BLOCK_ERASE) begin
                            s_d.state = ST_ERASE_CONFIRM;
                        end else if (code == CMD_LOCK_SETUP) begin
                            s_d.state = ST_LOCK_SECOND;
                        end else if (code == CMD_OTP_PROG) begin
                            s_d.state = ST_OTP_DATA;
                        end
                        s_d.mode = RD_STATUS;
                    end
                end
                ST_WORD_DATA: begin
                    fifoInValid = 1'b1;
                    fifoInData = pack_op(OP_WORD_PROG, s_q.firstAddr, wData);
                    s_d.busy = 1'b1;
                    s_d.status = s_q.status & ~STATUS_READY_BIT;
                end
                ST_BUF_COUNT: begin
                    if (wData[5:0] <= BUF_MAX_M1 && wData[DATA_W-1:6] == '0) begin
                        s_d.wordsLeft = wData[5:0];
                        s_d.state = ST_BUF_DATA;
                        fifoInValid = 1'b1;
                        fifoInData = pack_op(OP_BUF_PROG, s_q.firstAddr, wData);
                    end else begin
                        s_d.status = s_q.status | STATUS_ERR_MASK;
                    end
                end
                ST_BUF_DATA: begin
                    fifoInValid = 1'b1;
                    fifoInData = pack_op(OP_BUF_WORD, wAddr, wData);
                    s_d.wordsLeft = s_q.wordsLeft - 6'h01;
                    s_d.state = (s_q.wordsLeft == 6'h00) ? ST_BUF_CONFIRM : ST_BUF_DATA;
                end
                ST_BUF_CONFIRM: begin
                    if (code == CMD_CONFIRM) begin
                        fifoInValid = 1'b1;
                        fifoInData = pack_op(OP_BUF_PROG, s_q.firstAddr, wData);
                        s_d.busy = 1'b1;
                        s_d.status = s_q.status & ~STATUS_READY_BIT;
                    end else begin
                        s_d.status = s_q.status | STATUS_ERR_MASK;
                    end
                end
                ST_FACTORY_CONFIRM: begin
                    if (code == CMD_CONFIRM) begin
                        fifoInValid = 1'b1;
                        fifoInData = pack_op(OP_FACTORY_PROG, s_q.firstAddr, wData);
                        s_d.state = ST_FACTORY_DATA;
                        s_d.busy = 1'b1;
                        s_d.status = s_q.status & ~STATUS_READY_BIT;
                    end else begin
                        s_d.status = s_q.status | STATUS_ERR_MASK;
                    end
                end
                ST_FACTORY_DATA: begin
                    // Factory mode streams data words until the engine reports done.
                    fifoInValid = 1'b1;
                    fifoInData = pack_op(OP_BUF_WORD, wAddr, wData);
                    s_d.state = ST_FACTORY_DATA;
                end
                ST_ERASE_CONFIRM: begin
                    if (code == CMD_CONFIRM) begin
                        fifoInValid = 1'b1;
                        fifoInData = pack_op(OP_BLOCK_ERASE, s_q.firstAddr, wData);
                        s_d.busy = 1'b1;
                        s_d.status = s_q.status & ~STATUS_READY_BIT;
                    end else begin
                        s_d.status = s_q.status | STATUS_ERR_MASK;
                    end
                end
                ST_LOCK_SECOND: begin
                    fifoInValid = 1'b1;
                    if (code == CMD_LOCK_BLOCK) begin
                        fifoInData = pack_op(OP_LOCK, s_q.firstAddr, wData);
                    end else if (code == CMD_CONFIRM) begin
                        fifoInData = pack_op(OP_UNLOCK, s_q.firstAddr, wData);
                    end else if (code == CMD_LOCK_DOWN) begin
                        fifoInData = pack_op(OP_LOCK_DOWN, s_q.firstAddr, wData);
                    end else if (code == CMD_READ_CONFIG) begin
                        fifoInData = pack_op(OP_READ_CONFIG, s_q.firstAddr, wAddr[DATA_W-1:0]);
                    end else begin
                        fifoInValid = 1'b0;
                        s_d.status = s_q.status | STATUS_ERR_MASK;
                    end
                end
                ST_OTP_DATA: begin
                    fifoInValid = 1'b1;
                    fifoInData = pack_op(OP_OTP_PROG, s_q.firstAddr, wData);
                    s_d.busy = 1'b1;
                    s_d.status = s_q.status & ~STATUS_READY_BIT;
                end
                default: begin
                    s_d.state = ST_IDLE;
                end
            endcase
        end
        if (opDone && s_q.state == ST_FACTORY_DATA) begin
            s_d.state = ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.ceSync <= 3'h7;
            s_q.weSync <= 3'h7;
            s_q.mode <= RD_ARRAY;
            s_q.state <= ST_IDLE;
            s_q.status <= STATUS_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************
    // Operation queue towards the program/erase engine
    // ****************
    fcd_fifo #(
        .WIDTH(OP_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(fifoOutValid),
        .outReady(opValidReady && !opValid_q),
        .outData(fifoOutData)
    );

    // Engine-facing ports all come from flip-flops.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            opValid_q <= 1'b0;
            opWord_q <= '0;
        end else if (!opValid_q && opValidReady && fifoOutValid) begin
            opValid_q <= 1'b1;
            opWord_q <= fifoOutData;
        end else begin
            opValid_q <= 1'b0;
        end
    end

    assign opValid = opValid_q;
    assign opKind = opWord_q[OP_W-1 -: 4];
    assign opAddr = opWord_q[DATA_W +: ADDR_W];
    assign opData = opWord_q[DATA_W-1:0];
    assign readMode = s_q.mode;
    assign statusReg = s_q.status;
    assign busy = s_q.busy;
    assign suspended = s_q.suspended;
    assign abortPulse = s_q.abort;
    assign cmdStall = s_q.stall;
endmodule : fcd_decoder
`default_nettype wire

// file: rtl/fcd_pkg.sv
// Package of command codes, states and widths for the flash command decoder.
package fcd_pkg;

    // ****************
    // Widths
    // ****************
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int CMD_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int BUF_MAX_WORDS = 32;
    localparam logic [5:0] BUF_MAX_M1 = 6'h1F;

    // ****************
    // Command codes
    // ****************
    localparam logic [CMD_W-1:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [CMD_W-1:0] CMD_READ_ID = 8'h90;
    localparam logic [CMD_W-1:0] CMD_READ_QUERY = 8'h98;
    localparam logic [CMD_W-1:0] CMD_READ_STATUS = 8'h70;
    localparam logic [CMD_W-1:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [CMD_W-1:0] CMD_WORD_PROG = 8'h40;
    localparam logic [CMD_W-1:0] CMD_WORD_PROG_ALT = 8'h10;
    localparam logic [CMD_W-1:0] CMD_BUF_PROG = 8'hE8;
    localparam logic [CMD_W-1:0] CMD_CONFIRM = 8'hD0;
    localparam logic [CMD_W-1:0] CMD_FACTORY_PROG = 8'h80;
    localparam logic [CMD_W-1:0] CMD_BLOCK_ERASE = 8'h20;
    localparam logic [CMD_W-1:0] CMD_SUSPEND = 8'hB0;
    localparam logic [CMD_W-1:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [CMD_W-1:0] CMD_LOCK_BLOCK = 8'h01;
    localparam logic [CMD_W-1:0] CMD_LOCK_DOWN = 8'h2F;
    localparam logic [CMD_W-1:0] CMD_READ_CONFIG = 8'h03;
    localparam logic [CMD_W-1:0] CMD_OTP_PROG = 8'hC0;

    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic [7:0] STATUS_ERR_MASK = 8'h3A;
    localparam logic [7:0] STATUS_SUSPEND_MASK = 8'h44;
    localparam logic [7:0] STATUS_READY_BIT = 8'h80;

    // ****************
    // Read modes and operations
    // ****************
    typedef enum logic [1:0] {
        RD_ARRAY = 2'b00,
        RD_ID = 2'b01,
        RD_QUERY = 2'b10,
        RD_STATUS = 2'b11
    } fcd_read_mode_t;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_WORD_PROG = 4'h1,
        OP_BUF_PROG = 4'h2,
        OP_FACTORY_PROG = 4'h3,
        OP_BLOCK_ERASE = 4'h4,
        OP_LOCK = 4'h5,
        OP_UNLOCK = 4'h6,
        OP_LOCK_DOWN = 4'h7,
        OP_OTP_PROG = 4'h8,
        OP_READ_CONFIG = 4'h9,
        OP_SUSPEND = 4'hA,
        OP_RESUME = 4'hB,
        OP_BUF_WORD = 4'hC
    } fcd_op_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_WORD_DATA = 4'h1,
        ST_BUF_COUNT = 4'h2,
        ST_BUF_DATA = 4'h3,
        ST_BUF_CONFIRM = 4'h4,
        ST_FACTORY_CONFIRM = 4'h5,
        ST_FACTORY_DATA = 4'h6,
        ST_ERASE_CONFIRM = 4'h7,
        ST_LOCK_SECOND = 4'h8,
        ST_OTP_DATA = 4'h9
    } fcd_state_t;

endpackage : fcd_pkg

// file: rtl/fcd_fifo.sv
// Small valid/ready FIFO used on the decoded operation path.
`timescale 1ns/1ns
`default_nettype none
module fcd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [PW:0] count;
    } fcd_fifo_state_t;

    fcd_fifo_state_t s_q;
    fcd_fifo_state_t s_d;
    logic push;
    logic pop;

    always_comb begin
        push = inValid && (s_q.count != (PW+1)'(DEPTH));
        pop = outReady && (s_q.count != '0);
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wrPtr] = inData;
            s_d.wrPtr = (s_q.wrPtr == PW'(DEPTH - 1)) ? '0 : s_q.wrPtr + PW'(1);
        end
        if (pop) begin
            s_d.rdPtr = (s_q.rdPtr == PW'(DEPTH - 1)) ? '0 : s_q.rdPtr + PW'(1);
        end
        if (push && !pop) begin
            s_d.count = s_q.count + (PW+1)'(1);
        end else if (pop && !push) begin
            s_d.count = s_q.count - (PW+1)'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Flags come from the count alone, so they never disagree.
    assign inReady = (s_q.count != (PW+1)'(DEPTH));
    assign outValid = (s_q.count != '0);
    assign outData = s_q.mem[s_q.rdPtr];
endmodule : fcd_fifo
`default_nettype wire

// file: verification/fcd_decoder_properties.sv
// Port-level assertions for the flash command decoder.
`timescale 1ns/1ns
`default_nettype none
module fcd_decoder_properties
    import fcd_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic chipEnable_n,
    input wire logic writeEnable_n,
    input wire logic [ADDR_W-1:0] addrIn,
    input wire logic [DATA_W-1:0] dataIn,
    input wire logic opDone,
    input wire logic opError,
    input wire logic opValidReady,
    input wire logic opValid,
    input wire logic [3:0] opKind,
    input wire logic [ADDR_W-1:0] opAddr,
    input wire logic [DATA_W-1:0] opData,
    input wire logic [1:0] readMode,
    input wire logic [7:0] statusReg,
    input wire logic busy,
    input wire logic suspended,
    input wire logic abortPulse,
    input wire logic cmdStall
);
    // ****************
    // Checks
    // ****************
    // Cycles since write enable was low; saturates so it never wraps.
    logic [4:0] sinceWr_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sinceWr_q <= 5'h1F;
        end else if (!writeEnable_n) begin
            sinceWr_q <= 5'h00;
        end else if (sinceWr_q != 5'h1F) begin
            sinceWr_q <= sinceWr_q + 5'h01;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    chk_reset_state: assert property ($rose(arst_n) |-> statusReg == STATUS_RESET && readMode == RD_ARRAY)
        else $error("bad reset state");
    chk_op_kind_known: assert property (opValid |-> opKind inside {[4'h1:4'hC]})
        else $error("bad op kind");
    chk_op_fields_hold: assert property (!opValid |-> $stable(opKind) && $stable(opAddr) && $stable(opData))
        else $error("op fields moved");
    chk_word_status_mode: assert property (opValid && opKind == OP_WORD_PROG |-> readMode == RD_STATUS)
        else $error("mode not status");
    chk_busy_not_ready: assert property ($rose(busy) |-> !statusReg[7])
        else $error("ready while busy");
    chk_abort_single: assert property (abortPulse |=> !abortPulse)
        else $error("long abort");
    chk_abort_suspends: assert property (abortPulse |-> ##[0:3] suspended)
        else $error("no suspend");
    chk_mode_after_write: assert property ($changed(readMode) |-> sinceWr_q < 5'h0C)
        else $error("mode moved, no write");
    cov_word_op: cover property (opValid && opKind == OP_WORD_PROG);
    cov_abort: cover property (abortPulse);
    cov_stall: cover property (cmdStall);
    cov_id_mode: cover property (readMode == RD_ID);
endmodule : fcd_decoder_properties
bind fcd_decoder fcd_decoder_properties i_props (
    .clk(clk), .arst_n(arst_n), .chipEnable_n(chipEnable_n), .writeEnable_n(writeEnable_n),
    .addrIn(addrIn), .dataIn(dataIn), .opDone(opDone), .opError(opError), .opValidReady(opValidReady),
    .opValid(opValid), .opKind(opKind), .opAddr(opAddr), .opData(opData), .readMode(readMode),
    .statusReg(statusReg), .busy(busy), .suspended(suspended), .abortPulse(abortPulse), .cmdStall(cmdStall)
);
`default_nettype wire

// file: verification/fcd_engine_model.sv
// Behavioural program and erase engine fed by the decoder.
`timescale 1ns/1ns
`default_nettype none
module fcd_engine_model
    import fcd_pkg::*;
#(
    parameter int RUN_CYCLES = 300
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic stall,
    input wire logic opValid,
    input wire logic [3:0] opKind,
    input wire logic abortPulse,
    input wire logic busy,
    output logic opValidReady,
    output logic opDone,
    output logic opError
);
    // ****************
    // Engine
    // ****************
    int left;
    logic held;
    assign opValidReady = !stall;
    assign opError = 1'b0;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            left <= 0;
            held <= 1'b0;
            opDone <= 1'b0;
        end else begin
            opDone <= 1'b0;
            if (abortPulse) begin
                held <= 1'b1;
            end
            if (opValid && opKind == OP_RESUME) begin
                held <= 1'b0;
            end
            if (opValid && busy && opKind inside {OP_WORD_PROG, OP_BUF_PROG, OP_FACTORY_PROG,
                    OP_BLOCK_ERASE, OP_OTP_PROG}) begin
                left <= RUN_CYCLES;
            end else if (left > 0 && !held) begin
                left <= left - 1;
                opDone <= (left == 1);
            end
        end
    end
endmodule : fcd_engine_model
`default_nettype wire

// file: verification/flash_command_bus_decoder_tb.sv
// Self-checking bench for the flash command decoder.
`timescale 1ns/1ns
`default_nettype none
module flash_command_bus_decoder_tb;
    import fcd_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic chipEnable_n = 1'b1;
    logic writeEnable_n = 1'b1;
    logic [ADDR_W-1:0] addrIn = 24'h000000;
    logic [DATA_W-1:0] dataIn = 16'h0000;
    logic stall = 1'b0;
    logic opDone, opError, opValidReady, opValid, busy, suspended, abortPulse, cmdStall;
    logic [3:0] opKind;
    logic [3:0] lastKind = 4'h0;
    logic [ADDR_W-1:0] opAddr, lastAddr;
    logic [DATA_W-1:0] opData, lastData;
    logic [1:0] readMode;
    logic [7:0] statusReg;
    int mismatches = 0;
    int checksDone = 0;
    initial forever #50 clk = ~clk;
    fcd_decoder i_dut (.clk(clk), .arst_n(arst_n), .chipEnable_n(chipEnable_n), .writeEnable_n(writeEnable_n),
        .addrIn(addrIn), .dataIn(dataIn), .opDone(opDone), .opError(opError), .opValidReady(opValidReady),
        .opValid(opValid), .opKind(opKind), .opAddr(opAddr), .opData(opData), .readMode(readMode),
        .statusReg(statusReg), .busy(busy), .suspended(suspended), .abortPulse(abortPulse), .cmdStall(cmdStall));
    fcd_engine_model #(.RUN_CYCLES(300)) i_eng (.clk(clk), .arst_n(arst_n), .stall(stall), .busy(busy),
        .opValid(opValid), .opKind(opKind), .abortPulse(abortPulse),
        .opValidReady(opValidReady), .opDone(opDone), .opError(opError));
    // Operations pulse for one cycle, so they are latched here.
    always @(posedge clk) begin
        if (opValid === 1'b1) begin
            lastKind <= opKind;
            lastAddr <= opAddr;
            lastData <= opData;
        end
    end
    // ****************
    // Helpers
    // ****************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp, input string what);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_val
    // Write enable rises first and data then changes: capture must use that edge.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge clk);
        addrIn = a;
        dataIn = d;
        chipEnable_n = 1'b0;
        writeEnable_n = 1'b0;
        repeat (4) @(negedge clk);
        writeEnable_n = 1'b1;
        @(negedge clk);
        chipEnable_n = 1'b1;
        dataIn = ~d;
        repeat (7) @(negedge clk);
    endtask : wr
    task automatic chk_op(input logic [3:0] k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input bit useD);
        int n = 0;
        while (lastKind !== k && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk_val(24'(lastKind), 24'(k), "kind");
        chk_val(lastAddr, a, "address");
        if (useD) chk_val(24'(lastData), 24'(d), "data");
        if (n == 100) complete_run();
        lastKind = 4'h0;
    endtask : chk_op
    task automatic wait_idle();
        int n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk_val(24'(busy), 24'h0, "busy");
        if (n == 2000) complete_run();
    endtask : wait_idle
    // ****************
    // Scenarios
    // ****************
    task automatic t_modes();
        logic [7:0] codes [4] = '{8'h90, 8'h98, 8'h70, 8'hFF};
        logic [1:0] modes [4] = '{RD_ID, RD_QUERY, RD_STATUS, RD_ARRAY};
        chk_val(24'(statusReg), 24'h80, "status at reset");
        chk_val(24'(readMode), 24'h0, "mode at reset");
        for (int i = 0; i < 4; i++) begin
            wr(24'h00A000 + 24'(i), {8'hA5, codes[i]});
            chk_val(24'(readMode), 24'(modes[i]), "mode");
        end
        $display("test modes done");
    endtask : t_modes
    task automatic t_word();
        logic [7:0] codes [2] = '{8'h40, 8'h10};
        for (int i = 0; i < 2; i++) begin
            wr(24'h012340, {8'h00, codes[i]});
            chk_val(24'(readMode), 24'(RD_STATUS), "mode");
            wr(24'h012340, 16'h1234 + 16'(i));
            chk_op(OP_WORD_PROG, 24'h012340, 16'h1234 + 16'(i), 1);
            chk_val(24'({busy, statusReg[7]}), 24'h2, "busy and ready");
            wait_idle();
            chk_val(24'(statusReg[7]), 24'h1, "ready");
        end
        $display("test word done");
    endtask : t_word
    task automatic t_buffer();
        int k = 0;
        bit seen = 0;
        stall = 1'b1;
        wr(24'h020000, 16'h00E8);
        wr(24'h020000, 16'h001F);
        while (k < 32) begin
            if (cmdStall === 1'b1) begin
                stall = 1'b0;
                seen = 1;
                repeat (4) @(negedge clk);
            end else begin
                wr(24'h020000 + 24'(k), 16'h5000 + 16'(k));
                k++;
            end
        end
        stall = 1'b0;
        chk_val(24'(seen), 24'h1, "stall");
        wr(24'h020000, 16'h00D0);
        chk_op(OP_BUF_PROG, 24'h020000, 16'h0000, 0);
        wait_idle();
        $display("test buffer done");
    endtask : t_buffer
    task automatic t_erase();
        wr(24'h040010, 16'h0020);
        wr(24'h040010, 16'h00D0);
        chk_op(OP_BLOCK_ERASE, 24'h040010, 16'h0000, 0);
        wr(24'h000000, 16'h00B0);
        chk_val(24'(suspended), 24'h1, "suspended");
        wr(24'h000000, 16'h00D0);
        chk_val(24'(suspended), 24'h0, "resumed");
        wait_idle();
        $display("test erase done");
    endtask : t_erase
    task automatic t_lock_otp();
        logic [7:0] codes [4] = '{8'h01, 8'hD0, 8'h2F, 8'h03};
        logic [3:0] kinds [4] = '{OP_LOCK, OP_UNLOCK, OP_LOCK_DOWN, OP_READ_CONFIG};
        logic [ADDR_W-1:0] otp [2] = '{24'h000080, 24'h000089};
        for (int i = 0; i < 4; i++) begin
            wr(24'h034C21, 16'h0060);
            wr(24'h034C21, {8'h00, codes[i]});
            chk_op(kinds[i], 24'h034C21, 16'h4C21, i == 3);
        end
        for (int i = 0; i < 2; i++) begin
            wr(otp[i], 16'h00C0);
            wr(otp[i], 16'hBEE0 + 16'(i));
            chk_op(OP_OTP_PROG, otp[i], 16'hBEE0 + 16'(i), 1);
            wait_idle();
        end
        $display("test lock done");
    endtask : t_lock_otp
    task automatic t_fault_reset();
        wr(24'h050000, 16'h0020);
        wr(24'h050000, 16'h00FF);
        chk_val(24'(statusReg & STATUS_ERR_MASK), 24'h3A, "error set");
        wr(24'h050000, 16'h0050);
        chk_val(24'(statusReg & STATUS_ERR_MASK), 24'h00, "error cleared");
        wr(24'h060000, 16'h0080);
        wr(24'h060000, 16'h00D0);
        chk_op(OP_FACTORY_PROG, 24'h060000, 16'h0000, 0);
        chk_val(24'(busy), 24'h1, "busy");
        @(negedge clk);
        arst_n = 1'b0;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        chk_val(24'({busy, statusReg, readMode}), 24'h200, "after reset");
        $display("test reset done");
    endtask : t_fault_reset
    initial begin
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        t_modes();
        t_word();
        t_buffer();
        t_erase();
        t_lock_otp();
        t_fault_reset();
        complete_run();
    end
endmodule : flash_command_bus_decoder_tb
`default_nettype wire
